/* File: src/rail_seq_defines.svh */
// Constants for the rail sequencer and global power-good block.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register slave.
`ifndef RAIL_SEQ_DEFINES_SVH
`define RAIL_SEQ_DEFINES_SVH

`define CLK_HZ 25000000
`define MS_PER_S 1000
`define CNT_W 20
`define MS_W 5
`define DELAY_MS_DEF 5'h06
`define DELAY_MS_MIN 5'h03
`define DELAY_MS_MAX 5'h10
`define PG_SS_MS 5'h04
`define SS_NUM 32'h2
`define SS_DEN 32'h3

`define ADDR_W 5
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_IRQ_STS 5'h08
`define REG_IRQ_CLR 5'h0c
`define REG_IRQ_EN 5'h10

`define NSYNC 13
`define SY_GEN 0
`define SY_RUN 1
`define SY_TIME 2
`define SY_ORD 3
`define SY_EN1 4
`define SY_EN2 5
`define SY_PG1 6
`define SY_PG2 7
`define SY_FLT_LO 8
`define SY_FLT_HI 12
`define SYNC_RST 13'h000c

`define NIRQ 4
`define IRQ_PG_RISE 0
`define IRQ_PG_FALL 1
`define IRQ_FAULT 2
`define IRQ_SEQ_DONE 3

`endif

/* File: src/rail_seq_pkg.sv */
// Types for the rail sequencer and global power-good block.
// Assumes rail_seq_defines.svh sits on the include path.
`include "rail_seq_defines.svh"

package rail_seq_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_FIRST,
    SEQ_GAP,
    SEQ_SECOND
  } seq_state_t;

  typedef struct packed {
    logic [`NSYNC-1:0] sync1;
    logic [`NSYNC-1:0] sync2;
    seq_state_t seq;
    logic firstIsOne;
    logic seqTime;
    logic [`CNT_W-1:0] cnt;
    logic outOne;
    logic outTwo;
    logic [`CNT_W-1:0] rampOne;
    logic [`CNT_W-1:0] rampTwo;
    logic powerOk;
    logic [`MS_W-1:0] delayMs;
    logic [`NIRQ-1:0] irqSts;
    logic [`NIRQ-1:0] irqEn;
    logic ack;
    logic [31:0] rdata;
  } state_t;

endpackage : rail_seq_pkg

/* File: src/rail_sequencer_power_good.sv */
// Two-rail power sequencer, soft-start ramps and global power-good logic.
// Pins and regulator status arrive asynchronously and are synchronised here;
// software reaches the registers over Avalon-MM with waitrequest.
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rail_sequencer_power_good
  import rail_seq_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = `CLK_HZ / `MS_PER_S
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic globalEnable,
  input wire logic seqRunEnable,
  input wire logic timeModeSelect,
  input wire logic rail_order_select,
  input wire logic rail_one_enable_in,
  input wire logic rail_two_enable_in,
  input wire logic [1:0] rail_power_ok,
  input wire logic overcurrent_fault,
  input wire logic overvoltage_fault,
  input wire logic undervoltage_lockout_fault,
  input wire logic outputUndervoltageFault,
  input wire logic thermalShutdownFault,
  output logic stage_one_enable_out,
  output logic stage_one_enable_oe,
  output logic stage_two_enable_out,
  output logic stage_two_enable_oe,
  output logic [`CNT_W-1:0] railOneRamp,
  output logic [`CNT_W-1:0] railTwoRamp,
  output logic power_ok_global,
  output logic irq,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [`CNT_W-1:0] msCycles(input logic [`MS_W-1:0] ms);
    msCycles = `CNT_W'(32'(ms) * CYCLES_PER_MS);
  endfunction : msCycles

  // One step of a soft-start ramp; the same slope is used up and down
  function automatic logic [`CNT_W-1:0] rampNext(input logic [`CNT_W-1:0] cur,
                                                  input logic en,
                                                  input logic [`CNT_W-1:0] top);
    if (cur > top) begin
      rampNext = top;
    end else if (en) begin
      rampNext = (cur == top) ? top : cur + 1'b1;
    end else begin
      rampNext = (cur == '0) ? cur : cur - 1'b1;
    end
  endfunction : rampNext

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pin view

  state_t st_r;
  state_t st_nxt;

  logic [`NSYNC-1:0] pinVec;
  logic genOn;
  logic runOn;
  logic timeMode;
  logic orderHigh;
  logic railOneEn;
  logic railTwoEn;
  logic [1:0] railOk;
  logic faultAny;
  logic [`CNT_W-1:0] delayCyc;
  logic [`CNT_W-1:0] timeSsCyc;
  logic [`CNT_W-1:0] ssCyc;
  logic [`CNT_W-1:0] gapCyc;
  logic rampOneDone;
  logic rampTwoDone;
  logic firstOk;
  logic powerOkNxt;
  logic wrAcc;
  logic rdCap;
  logic [`NIRQ-1:0] events;
  logic [`NIRQ-1:0] clrMask;
  logic [`MS_W-1:0] wrMs;

  assign pinVec = {thermalShutdownFault, outputUndervoltageFault,
                   undervoltage_lockout_fault, overvoltage_fault,
                   overcurrent_fault, rail_power_ok, rail_two_enable_in,
                   rail_one_enable_in, rail_order_select, timeModeSelect,
                   seqRunEnable, globalEnable};

  assign genOn = st_r.sync2[`SY_GEN];
  assign runOn = st_r.sync2[`SY_RUN];
  assign timeMode = st_r.sync2[`SY_TIME];
  assign orderHigh = st_r.sync2[`SY_ORD];
  assign railOneEn = genOn & st_r.sync2[`SY_EN1];
  assign railTwoEn = genOn & st_r.sync2[`SY_EN2];
  assign railOk = st_r.sync2[`SY_PG2:`SY_PG1];
  assign faultAny = |st_r.sync2[`SY_FLT_HI:`SY_FLT_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Timing figures

  assign delayCyc = msCycles(st_r.delayMs);
  assign timeSsCyc = `CNT_W'((32'(delayCyc) * `SS_NUM) / `SS_DEN);
  assign ssCyc = timeMode ? timeSsCyc : msCycles(`PG_SS_MS);
  assign gapCyc = st_r.seqTime ? delayCyc - timeSsCyc : delayCyc;

  assign rampOneDone = railOneEn & (st_r.rampOne == ssCyc);
  assign rampTwoDone = railTwoEn & (st_r.rampTwo == ssCyc);
  assign firstOk = st_r.firstIsOne ? railOk[0] : railOk[1];

  // Combined rail status gated by ramps, faults and enable
  assign powerOkNxt = genOn & (&railOk) & rampOneDone & rampTwoDone
                      & ~faultAny;

  ////////////////////////////////////////////////////////////////////////////
  // Bus view

  assign wrAcc = avs_write & st_r.ack;
  assign rdCap = avs_read & ~st_r.ack;
  assign clrMask = (wrAcc && avs_address == `REG_IRQ_CLR) ?
                   avs_writedata[`NIRQ-1:0] : '0;
  assign wrMs = avs_writedata[`MS_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    events = '0;
    if (clkEn) begin
      st_nxt.sync1 = pinVec;
      st_nxt.sync2 = st_r.sync1;

      st_nxt.rampOne = rampNext(st_r.rampOne, railOneEn, ssCyc);
      st_nxt.rampTwo = rampNext(st_r.rampTwo, railTwoEn, ssCyc);

      st_nxt.powerOk = powerOkNxt;
      events[`IRQ_PG_RISE] = powerOkNxt & ~st_r.powerOk;
      events[`IRQ_PG_FALL] = ~powerOkNxt & st_r.powerOk;
      events[`IRQ_FAULT] = faultAny;

      case (st_r.seq)
        SEQ_IDLE: begin
          if (runOn) begin
            st_nxt.seqTime = timeMode;
            // Delay mode relies on the board tying order high and wiring 1 to 1
            st_nxt.firstIsOne = timeMode | orderHigh;
            st_nxt.outOne = timeMode | orderHigh;
            st_nxt.outTwo = ~(timeMode | orderHigh);
            st_nxt.cnt = '0;
            st_nxt.seq = SEQ_FIRST;
          end
        end
        SEQ_FIRST: begin
          if (st_r.seqTime) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_nxt.cnt >= timeSsCyc) begin
              st_nxt.cnt = '0;
              st_nxt.seq = SEQ_GAP;
            end
          end else if (firstOk) begin
            st_nxt.cnt = '0;
            st_nxt.seq = SEQ_GAP;
          end
        end
        SEQ_GAP: begin
          st_nxt.cnt = st_r.cnt + 1'b1;
          if (st_nxt.cnt >= gapCyc) begin
            st_nxt.cnt = '0;
            st_nxt.outOne = 1'b1;
            st_nxt.outTwo = 1'b1;
            st_nxt.seq = SEQ_SECOND;
            events[`IRQ_SEQ_DONE] = 1'b1;
          end
        end
        SEQ_SECOND: begin
          st_nxt.cnt = '0;
        end
        default: begin
          st_nxt.seq = SEQ_IDLE;
        end
      endcase

      if (!runOn) begin
        st_nxt.seq = SEQ_IDLE;
        st_nxt.cnt = '0;
        st_nxt.outOne = 1'b0;
        st_nxt.outTwo = 1'b0;
        events[`IRQ_SEQ_DONE] = 1'b0;
      end

      // Set beats clear in the same cycle
      st_nxt.irqSts = (st_r.irqSts & ~clrMask) | events;

      // One wait state: answer in the cycle after the request appears
      st_nxt.ack = (avs_read | avs_write) & ~st_r.ack;
      if (rdCap) begin
        case (avs_address)
          `REG_CTRL: st_nxt.rdata = 32'(st_r.delayMs);
          `REG_STATUS: st_nxt.rdata = 32'({runOn, faultAny, orderHigh, timeMode,
                                           rampTwoDone, rampOneDone, st_r.outTwo,
                                           st_r.outOne, st_r.powerOk});
          `REG_IRQ_STS: st_nxt.rdata = 32'(st_r.irqSts);
          `REG_IRQ_EN: st_nxt.rdata = 32'(st_r.irqEn);
          default: st_nxt.rdata = 32'h0;
        endcase
      end
      if (wrAcc) begin
        case (avs_address)
          `REG_CTRL: begin
            // Whole word is compared first so that large values clamp high, not low
            if (avs_writedata > 32'(`DELAY_MS_MAX)) begin
              st_nxt.delayMs = `DELAY_MS_MAX;
            end else if (wrMs < `DELAY_MS_MIN) begin
              st_nxt.delayMs = `DELAY_MS_MIN;
            end else begin
              st_nxt.delayMs = wrMs;
            end
          end
          `REG_IRQ_EN: st_nxt.irqEn = avs_writedata[`NIRQ-1:0];
          default: st_nxt.irqEn = st_r.irqEn;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{sync1: `SYNC_RST, sync2: `SYNC_RST,
                seq: SEQ_IDLE, firstIsOne: 1'b1, seqTime: 1'b1,
                cnt: '0, outOne: 1'b0, outTwo: 1'b0,
                rampOne: '0, rampTwo: '0, powerOk: 1'b0,
                delayMs: `DELAY_MS_DEF, irqSts: '0, irqEn: '0,
                ack: 1'b0, rdata: 32'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open-drain with pull-up: pull low while off, release for high
  assign stage_one_enable_out = st_r.outOne;
  assign stage_one_enable_oe = ~st_r.outOne;
  assign stage_two_enable_out = st_r.outTwo;
  assign stage_two_enable_oe = ~st_r.outTwo;
  assign railOneRamp = st_r.rampOne;
  assign railTwoRamp = st_r.rampTwo;
  assign power_ok_global = st_r.powerOk;
  assign irq = |(st_r.irqSts & st_r.irqEn);
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  pg_enable_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && !genOn |=> !power_ok_global)
    else $error("power-good high while enable low");

  pg_fault_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && faultAny |=> !power_ok_global)
    else $error("power-good high during a fault");

  pg_after_ramp_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && !(rampOneDone && rampTwoDone) |=> !power_ok_global)
    else $error("power-good before soft start done");

  pg_rail_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && !(&railOk) |=> !power_ok_global)
    else $error("power-good with a rail below threshold");

  seq_run_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && !runOn |=> !stage_one_enable_out && !stage_two_enable_out
                        && st_r.seq == SEQ_IDLE && st_r.cnt == '0)
    else $error("sequencer active with run-enable low");

  seq_order_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && st_r.seq == SEQ_IDLE && runOn && !timeMode && !orderHigh
    |=> stage_two_enable_out && !stage_one_enable_out)
    else $error("order low did not start rail two first");

  seq_order_high_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && st_r.seq == SEQ_IDLE && runOn && (timeMode || orderHigh)
    |=> stage_one_enable_out && !stage_two_enable_out)
    else $error("rail one not started first");

  ramp_up_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && railOneEn && st_r.rampOne < ssCyc
    |=> st_r.rampOne == $past(st_r.rampOne) + 1'b1)
    else $error("rail one ramp did not step up");

  ramp_down_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && !railTwoEn && st_r.rampTwo != '0 && st_r.rampTwo <= ssCyc
    |=> st_r.rampTwo == $past(st_r.rampTwo) - 1'b1)
    else $error("rail two ramp did not step down");

  delay_range_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_r.delayMs >= `DELAY_MS_MIN && st_r.delayMs <= `DELAY_MS_MAX)
    else $error("sequencing delay out of range");

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  pg_rails_ok_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    power_ok_global |-> (&$past(railOk)))
    else $error("power-good high with a rail not good");

  seq_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && st_r.seq == SEQ_IDLE && runOn |=> st_r.seq == SEQ_FIRST)
    else $error("sequencer did not start on run-enable");

  ss_first_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && runOn && st_r.seq == SEQ_FIRST && st_r.seqTime
    && st_r.cnt < timeSsCyc - 1'b1 |=> st_r.seq == SEQ_FIRST)
    else $error("first soft start cut short");

  gap_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && runOn && st_r.seq == SEQ_GAP
    && st_r.cnt < gapCyc - 1'b1 |=> st_r.seq == SEQ_GAP)
    else $error("sequencing gap cut short");

  gap_end_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && runOn && st_r.seq == SEQ_GAP && st_r.cnt >= gapCyc - 1'b1
    |=> stage_one_enable_out && stage_two_enable_out && st_r.irqSts[`IRQ_SEQ_DONE])
    else $error("second rail not enabled after the gap");

  pg_first_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && runOn && st_r.seq == SEQ_FIRST && !st_r.seqTime && !firstOk
    |=> st_r.seq == SEQ_FIRST)
    else $error("gap started before first rail good");

  pg_first_go_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && runOn && st_r.seq == SEQ_FIRST && !st_r.seqTime && firstOk
    |=> st_r.seq == SEQ_GAP && st_r.cnt == '0)
    else $error("gap not started on first rail good");

  seq_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && runOn && st_r.seq == SEQ_SECOND
    |=> st_r.seq == SEQ_SECOND && stage_one_enable_out && stage_two_enable_out)
    else $error("stage outputs dropped while running");

  ramp_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn |=> st_r.rampOne <= $past(ssCyc) && st_r.rampTwo <= $past(ssCyc))
    else $error("ramp above soft-start length");

  ss_two_thirds_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    32'(timeSsCyc) * `SS_DEN <= 32'(delayCyc) * `SS_NUM
    && 32'(timeSsCyc) * `SS_DEN + `SS_DEN > 32'(delayCyc) * `SS_NUM)
    else $error("soft start not two thirds of delay");

  ramp_down_one_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && !railOneEn && st_r.rampOne != '0 && st_r.rampOne <= ssCyc
    |=> st_r.rampOne == $past(st_r.rampOne) - 1'b1)
    else $error("rail one ramp did not step down");

  ramp_up_two_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && railTwoEn && st_r.rampTwo < ssCyc
    |=> st_r.rampTwo == $past(st_r.rampTwo) + 1'b1)
    else $error("rail two ramp did not step up");

  delay_clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && avs_write && !avs_waitrequest && avs_address == `REG_CTRL
    && avs_writedata > 32'(`DELAY_MS_MAX) |=> st_r.delayMs == `DELAY_MS_MAX)
    else $error("large delay not clamped to maximum");

  irq_fault_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clkEn && faultAny |=> st_r.irqSts[`IRQ_FAULT])
    else $error("fault status bit not set");

  clk_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !clkEn |=> $stable(st_r))
    else $error("state moved with clock enable low");

endmodule : rail_sequencer_power_good

`default_nettype wire

/* File: verif/buck_stage_model.sv */
// Behavioural model of the two buck power stages seen from the sequencer.
// Assumes enable levels are the resolved board wires with pull-ups applied.
`timescale 1ns/1ps
`default_nettype none

module buck_stage_model #(
  parameter int SETTLE = 40
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] enIn,
  input wire logic droop,
  output logic [1:0] powerOk
);
  int cnt [2];

  ////////////////////////////////////////////////////////////////////////////////
  // Soft start runs while enabled, then the rail reports good
  always @(posedge clk_sys or negedge rst_b) begin
    for (int k = 0; k < 2; k++) begin
      if (!rst_b || !enIn[k]) begin
        cnt[k] <= 0;
      end else if (cnt[k] < SETTLE) begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end

  // Droop models both outputs falling under the good threshold
  assign powerOk[0] = enIn[0] && cnt[0] >= SETTLE && !droop;
  assign powerOk[1] = enIn[1] && cnt[1] >= SETTLE && !droop;
endmodule : buck_stage_model
`default_nettype wire

/* File: verif/rail_sequencer_power_good_tb_top.sv */
// Self-checking bench for the rail sequencer with a buck stage model.
// Assumes CYCLES_PER_MS is shrunk to 10 and the bus answers with waitrequest.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nErrors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module rail_sequencer_power_good_tb_top;
  import rail_seq_pkg::*;
  localparam int N = 10;
  localparam int SETTLE = 4 * N;
  logic clk_sys = 1'b0;
  logic rstB = 1'b0;
  logic globalEnable = 1'b1;
  logic seqRunEnable = 1'b0;
  logic clkEn = 1'b1;
  logic [31:0] expV;
  logic timeModeSelect = 1'b1;
  logic orderSel = 1'b1;
  logic [4:0] fault = 5'h00;
  logic droop = 1'b0;
  logic [`ADDR_W-1:0] avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = '0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic outOne, oeOne, outTwo, oeTwo, powerOkGlobal, irq, lvlOne, lvlTwo;
  logic [1:0] railOk;
  logic [`CNT_W-1:0] rampOne, rampTwo;
  logic [31:0] expQ [$];
  int nErrors = 0;
  int nTests = 0;
  int c;
  int r;

  always #20 clk_sys = ~clk_sys;

  // Open-drain enables with pull-ups, wired output n to rail enable n
  assign lvlOne = oeOne ? 1'b0 : 1'b1;
  assign lvlTwo = oeTwo ? 1'b0 : 1'b1;

  rail_sequencer_power_good #(.CYCLES_PER_MS(N)) dut (
    .clk_sys(clk_sys), .rst_b(rstB), .clkEn(clkEn), .globalEnable(globalEnable),
    .seqRunEnable(seqRunEnable), .timeModeSelect(timeModeSelect),
    .rail_order_select(orderSel), .rail_one_enable_in(lvlOne), .rail_two_enable_in(lvlTwo),
    .rail_power_ok(railOk), .overcurrent_fault(fault[0]), .overvoltage_fault(fault[1]),
    .undervoltage_lockout_fault(fault[2]), .outputUndervoltageFault(fault[3]),
    .thermalShutdownFault(fault[4]), .stage_one_enable_out(outOne),
    .stage_one_enable_oe(oeOne), .stage_two_enable_out(outTwo), .stage_two_enable_oe(oeTwo),
    .railOneRamp(rampOne), .railTwoRamp(rampTwo), .power_ok_global(powerOkGlobal),
    .irq(irq), .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest)
  );

  buck_stage_model #(.SETTLE(SETTLE)) stages (
    .clk_sys(clk_sys), .rst_b(rstB), .enIn({lvlTwo, lvlOne}), .droop(droop), .powerOk(railOk)
  );

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master and read-result watcher
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avsWaitrequest === 1'b0) break;
    end
    if (i == 50) begin
      nErrors++;
      $display("[ERR] %0t bus answer missing", $time);
      tally_and_finish();
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  always @(posedge clk_sys) begin
    if (avsRead === 1'b1 && avsWaitrequest === 1'b0) begin
      if (expQ.size() == 0) begin
        nErrors++;
        $display("[ERR] %0t unexpected read result", $time);
      end else begin
        expV = expQ.pop_front();
        `CHK(avsReaddata, expV)
      end
    end
  end

  task automatic wait_out(input int which, output int cnt);
    for (cnt = 1; cnt <= 500; cnt++) begin
      @(negedge clk_sys);
      if ((which == 1 ? outOne : outTwo) === 1'b1) break;
    end
    if (cnt > 500) begin
      nErrors++;
      $display("[ERR] %0t stage output never rose", $time);
      tally_and_finish();
    end
  endtask : wait_out

  initial begin
    repeat (20000) @(posedge clk_sys);
    nErrors++;
    $display("[ERR] %0t run too long", $time);
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(17));
    repeat (10) @(posedge clk_sys);
    rstB <= 1'b1;
    rd(`REG_CTRL, 32'h6);
    rd(`REG_IRQ_EN, 32'h0);
    rd(5'h14, 32'h0);
    rd(`REG_IRQ_CLR, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h1);
    rd(`REG_CTRL, 32'h3);
    bus(1'b1, `REG_CTRL, 32'h21);
    rd(`REG_CTRL, 32'h10);
    r = 3 + $urandom % 14;
    bus(1'b1, `REG_CTRL, r);
    rd(`REG_CTRL, r);
    bus(1'b1, `REG_CTRL, 32'h3);
    $display("registers test done");
    @(posedge clk_sys);
    seqRunEnable <= 1'b1;
    wait_out(1, c);
    `CHK(outTwo, 1'b0)
    wait_out(2, c);
    `CHK(c, 3 * N)
    repeat (150) @(posedge clk_sys);
    rd(`REG_STATUS, 32'h17f);
    rd(`REG_IRQ_STS, 32'h9);
    bus(1'b1, `REG_IRQ_EN, 32'hf);
    @(negedge clk_sys);
    `CHK(irq, 1'b1)
    bus(1'b1, `REG_IRQ_CLR, 32'hf);
    @(negedge clk_sys);
    `CHK(irq, 1'b0)
    $display("time mode test done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      if (i < 5) fault[i] <= 1'b1;
      else droop <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(`REG_STATUS, i < 5 ? 32'h1fe : 32'h17e);
      @(negedge clk_sys);
      `CHK(irq, 1'b1)
      @(posedge clk_sys);
      fault <= 5'h00;
      droop <= 1'b0;
      repeat (8) @(posedge clk_sys);
      bus(1'b1, `REG_IRQ_CLR, 32'hf);
      rd(`REG_STATUS, 32'h17f);
      rd(`REG_IRQ_STS, 32'h0);
    end
    $display("fault test done");
    @(posedge clk_sys);
    globalEnable <= 1'b0;
    repeat (8) @(posedge clk_sys);
    `CHK(rampOne > 0 && rampOne < 20, 1'b1)
    // Freeze the block and check the ramp stands still
    clkEn <= 1'b0;
    @(posedge clk_sys);
    r = rampOne;
    repeat (10) @(posedge clk_sys);
    `CHK(rampOne, r)
    clkEn <= 1'b1;
    repeat (25) @(posedge clk_sys);
    `CHK(rampOne, 20'h0)
    rd(`REG_STATUS, 32'h166);
    @(posedge clk_sys);
    globalEnable <= 1'b1;
    repeat (30) @(posedge clk_sys);
    `CHK(rampTwo, 20'h14)
    @(posedge clk_sys);
    seqRunEnable <= 1'b0;
    repeat (40) @(posedge clk_sys);
    rd(`REG_STATUS, 32'h60);
    $display("enable test done");
    @(posedge clk_sys);
    timeModeSelect <= 1'b0;
    orderSel <= 1'b0;
    repeat (4) @(posedge clk_sys);
    seqRunEnable <= 1'b1;
    wait_out(2, c);
    `CHK(outOne, 1'b0)
    wait_out(1, c);
    `CHK(c >= SETTLE + 3 * N && c <= SETTLE + 3 * N + 6, 1'b1)
    repeat (60) @(posedge clk_sys);
    rd(`REG_STATUS, 32'h11f);
    // Let the watcher compare the last read before the verdict
    @(negedge clk_sys);
    $display("power-good mode test done");
    tally_and_finish();
  end
endmodule : rail_sequencer_power_good_tb_top
`default_nettype wire
